// ---- core/ast_pkg.sv ----
// Constants, states and carrier types of the asynchronous serial transceiver.
// Assumes a 32-bit AHB-Lite slave port with word-aligned registers.
package ast_pkg;
  localparam logic [7:0] OFS_TXSC = 8'h00;
  localparam logic [7:0] OFS_RXSC = 8'h04;
  localparam logic [7:0] OFS_BAUD = 8'h08;
  localparam logic [7:0] OFS_DIVL = 8'h0C;
  localparam logic [7:0] OFS_DIVH = 8'h10;
  localparam logic [7:0] OFS_TXDATA = 8'h14;
  localparam logic [7:0] OFS_RXDATA = 8'h18;
  localparam logic [7:0] OFS_IRQ = 8'h1C;
  localparam int TXSC_NINE = 6;
  localparam int TXSC_EN = 5;
  localparam int TXSC_SYNC = 4;
  localparam int TXSC_FAST = 2;
  localparam int TXSC_EMPTY = 1;
  localparam int TXSC_BIT9 = 0;
  localparam int RXSC_PORT = 7;
  localparam int RXSC_NINE = 6;
  localparam int RXSC_CONT = 4;
  localparam int RXSC_ADDR = 3;
  localparam int RXSC_FERR = 2;
  localparam int RXSC_OERR = 1;
  localparam int RXSC_BIT9 = 0;
  localparam int BAUD_IDLE = 6;
  localparam int BAUD_INV = 4;
  localparam int BAUD_WIDE = 3;
  localparam int IRQ_GLOBAL = 0;
  localparam int IRQ_PERIPH = 1;
  localparam int IRQ_TRANSMIT_IRQ_ENABLE = 2;
  localparam int IRQ_RXIE = 3;
  localparam int IRQ_TXF = 4;
  localparam int IRQ_RXF = 5;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  localparam logic [3:0] SAMPLE_FIRST = 4'h7;
  localparam logic [3:0] SAMPLE_MID = 4'h8;
  localparam logic [3:0] SAMPLE_LAST = 4'h9;
  localparam logic [3:0] LAST_TICK = 4'hF;
  localparam logic [1:0] SLOW_PRESCALE = 2'h3;
  localparam logic [3:0] BITS_EIGHT = 4'h8;
  localparam logic [3:0] BITS_NINE = 4'h9;
  typedef enum logic [1:0] {TX_IDLE, TX_START, TX_DATA, TX_STOP} ast_tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ast_rx_state_t;
  typedef struct packed {
    logic ferr;
    logic [8:0] data;
  } ast_rx_entry_t;
endpackage

// ---- core/ast_transceiver.sv ----
// Asynchronous NRZ serial transceiver with an AHB-Lite register slave.
// Assumes one clock, a synchronous active-low reset and a single master.
//
// Behaviour
// - shifter-empty set while shifter idle
// - shifter-empty flag drives no interrupt
// - nine-bit select sends ninth bit
// - all nine bits move together
// - transmitter enable sets buffer-free flag
// - transmit interrupt when all enables set
// - data write starts transmission when enabled
// - receive sampling at sixteen per bit
// - completed characters enter two-entry FIFO
// - receiver needs continuous, async, port enable
// - false start bit abandoned silently
// - full bit time to each centre
// - stop sample low marks framing error
// - push after stop, read pops oldest
// - overrun blocks reception until cleared
// - receive-pending follows unread characters
// - receive interrupt when all enables set
// - least significant bit first
// - start low, data, stop high, idle high unless polarity_invert inverts the transmit pin
// - written character waits for stop bit
// - buffer-free while enabled and holding empty
//
// The placing of the registers and the AHB-Lite interface to the registers were chosen for this implementation.
`timescale 1ns/1ps
module ast_transceiver #(
  parameter int FIFO_DEPTH = 2
) (
  input wire logic core_clk, // 25 MHz system clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic hsel, // Slave select
  input wire logic [31:0] haddr, // Byte address
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write when high
  input wire logic [2:0] hsize, // Transfer size
  input wire logic [31:0] hwdata, // Write data
  input wire logic hready, // Bus ready
  output logic hreadyout, // Slave ready
  output logic [31:0] hrdata, // Read data
  output logic hresp, // Always OKAY
  input wire logic serial_input_pin, // Receive line
  output logic serial_output_pin, // Transmit line
  output logic serial_output_oe_n, // Transmit drive, low drives
  output logic tx_irq, // Transmit interrupt request
  output logic rx_irq // Receive interrupt request
);
  localparam int PTR_W = $clog2(FIFO_DEPTH);

  if (FIFO_DEPTH < 2 || (FIFO_DEPTH & (FIFO_DEPTH - 1)) != 0)
  begin : g_bad_depth
    $error("FIFO_DEPTH must be a power of two, at least 2");
  end

  // Control bits
  logic nine_bit_transmit_select;
  logic transmitter_enable;
  logic sync_mode;
  logic high_speed_divisor_select;
  logic transmit_ninth_bit;
  logic port_enable;
  logic nine_bit_receive_select;
  logic continuous_receive_enable;
  logic address_detect_enable;
  logic polarity_invert;
  logic wide_divisor_select;
  logic [7:0] divisor_low_byte;
  logic [7:0] divisor_high_byte;
  logic global_irq_enable;
  logic peripheral_irq_enable;
  logic transmit_irq_enable;
  logic receive_irq_enable;

  // Bus slave
  logic bus_pend;
  logic bus_write;
  logic [7:0] bus_addr;
  logic bus_wr;
  logic bus_rd;
  logic tx_data_write;
  logic rx_data_read;

  // Divisor
  logic [15:0] div_cnt;
  logic [15:0] divisor;
  logic [1:0] prescale;
  logic tick;

  // Transmitter
  ast_pkg::ast_tx_state_t tx_state;
  logic [3:0] tx_ticks;
  logic [3:0] tx_bits;
  logic [3:0] tx_len;
  logic [8:0] transmit_shifter;
  logic [8:0] transmit_holding_buffer;
  logic hold_valid;
  logic tx_on;
  logic tx_line;
  logic shifter_empty_flag;
  logic transmit_buffer_free_flag;

  // Receiver
  logic rx_s1;
  logic rx_s2;
  logic rx_s3;
  logic rx_level;
  logic rx_prev;
  ast_pkg::ast_rx_state_t rx_state;
  logic [3:0] rx_ticks;
  logic [3:0] rx_bits;
  logic [2:0] rx_win;
  logic [2:0] next_win;
  logic rx_maj;
  logic rx_active;
  logic [8:0] receive_shifter;
  logic [8:0] rx_char;
  logic rx_done;
  logic rx_keep;
  logic overrun;
  ast_pkg::ast_rx_entry_t fifo [FIFO_DEPTH];
  ast_pkg::ast_rx_entry_t head;
  logic [PTR_W-1:0] wr_ptr;
  logic [PTR_W-1:0] rd_ptr;
  logic [PTR_W:0] fifo_count;
  logic fifo_push;
  logic fifo_pop;
  logic receive_pending_flag;

  // AHB-Lite: one wait state so read data comes from a flip-flop
  assign bus_wr = bus_pend && bus_write;
  assign bus_rd = bus_pend && !bus_write;
  assign tx_data_write = bus_wr && bus_addr == ast_pkg::OFS_TXDATA;
  assign rx_data_read = bus_rd && bus_addr == ast_pkg::OFS_RXDATA;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      bus_pend <= 1'b0;
      bus_write <= 1'b0;
      bus_addr <= 8'h00;
      hreadyout <= 1'b1;
    end
    else if (bus_pend)
    begin
      bus_pend <= 1'b0;
      hreadyout <= 1'b1;
    end
    else if (hsel && hready && htrans == ast_pkg::HTRANS_NONSEQ
             && hsize == ast_pkg::HSIZE_WORD)
    begin
      bus_pend <= 1'b1;
      bus_write <= hwrite;
      bus_addr <= (haddr[31:8] == 24'h000000) ? haddr[7:0] : 8'hFF;
      hreadyout <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      hresp <= 1'b0;
    end
    else
    begin
      hresp <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      hrdata <= 32'h00000000;
    end
    else if (bus_rd)
    begin
      hrdata <= 32'h00000000;
      unique case (bus_addr)
        ast_pkg::OFS_TXSC:
        begin
          hrdata[ast_pkg::TXSC_NINE] <= nine_bit_transmit_select;
          hrdata[ast_pkg::TXSC_EN] <= transmitter_enable;
          hrdata[ast_pkg::TXSC_SYNC] <= sync_mode;
          hrdata[ast_pkg::TXSC_FAST] <= high_speed_divisor_select;
          hrdata[ast_pkg::TXSC_EMPTY] <= shifter_empty_flag;
          hrdata[ast_pkg::TXSC_BIT9] <= transmit_ninth_bit;
        end
        ast_pkg::OFS_RXSC:
        begin
          hrdata[ast_pkg::RXSC_PORT] <= port_enable;
          hrdata[ast_pkg::RXSC_NINE] <= nine_bit_receive_select;
          hrdata[ast_pkg::RXSC_CONT] <= continuous_receive_enable;
          hrdata[ast_pkg::RXSC_ADDR] <= address_detect_enable;
          hrdata[ast_pkg::RXSC_FERR] <= head.ferr;
          hrdata[ast_pkg::RXSC_OERR] <= overrun;
          hrdata[ast_pkg::RXSC_BIT9] <= head.data[8];
        end
        ast_pkg::OFS_BAUD:
        begin
          hrdata[ast_pkg::BAUD_IDLE] <= rx_state == ast_pkg::RX_IDLE;
          hrdata[ast_pkg::BAUD_INV] <= polarity_invert;
          hrdata[ast_pkg::BAUD_WIDE] <= wide_divisor_select;
        end
        ast_pkg::OFS_DIVL: hrdata[7:0] <= divisor_low_byte;
        ast_pkg::OFS_DIVH: hrdata[7:0] <= divisor_high_byte;
        ast_pkg::OFS_RXDATA: hrdata[7:0] <= head.data[7:0];
        ast_pkg::OFS_IRQ:
        begin
          hrdata[ast_pkg::IRQ_GLOBAL] <= global_irq_enable;
          hrdata[ast_pkg::IRQ_PERIPH] <= peripheral_irq_enable;
          hrdata[ast_pkg::IRQ_TRANSMIT_IRQ_ENABLE] <= transmit_irq_enable;
          hrdata[ast_pkg::IRQ_RXIE] <= receive_irq_enable;
          hrdata[ast_pkg::IRQ_TXF] <= transmit_buffer_free_flag;
          hrdata[ast_pkg::IRQ_RXF] <= receive_pending_flag;
        end
        default: hrdata <= 32'h00000000;
      endcase
    end
  end

  // Software-written control bits
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      nine_bit_transmit_select <= 1'b0;
      transmitter_enable <= 1'b0;
      sync_mode <= 1'b0;
      high_speed_divisor_select <= 1'b0;
      transmit_ninth_bit <= 1'b0;
      port_enable <= 1'b0;
      nine_bit_receive_select <= 1'b0;
      continuous_receive_enable <= 1'b0;
      address_detect_enable <= 1'b0;
      polarity_invert <= 1'b0;
      wide_divisor_select <= 1'b0;
      divisor_low_byte <= 8'h00;
      divisor_high_byte <= 8'h00;
      global_irq_enable <= 1'b0;
      peripheral_irq_enable <= 1'b0;
      transmit_irq_enable <= 1'b0;
      receive_irq_enable <= 1'b0;
    end
    else if (bus_wr)
    begin
      unique case (bus_addr)
        ast_pkg::OFS_TXSC:
        begin
          nine_bit_transmit_select <= hwdata[ast_pkg::TXSC_NINE];
          transmitter_enable <= hwdata[ast_pkg::TXSC_EN];
          sync_mode <= hwdata[ast_pkg::TXSC_SYNC];
          high_speed_divisor_select <= hwdata[ast_pkg::TXSC_FAST];
          transmit_ninth_bit <= hwdata[ast_pkg::TXSC_BIT9];
        end
        ast_pkg::OFS_RXSC:
        begin
          port_enable <= hwdata[ast_pkg::RXSC_PORT];
          nine_bit_receive_select <= hwdata[ast_pkg::RXSC_NINE];
          continuous_receive_enable <= hwdata[ast_pkg::RXSC_CONT];
          address_detect_enable <= hwdata[ast_pkg::RXSC_ADDR];
        end
        ast_pkg::OFS_BAUD:
        begin
          polarity_invert <= hwdata[ast_pkg::BAUD_INV];
          wide_divisor_select <= hwdata[ast_pkg::BAUD_WIDE];
        end
        ast_pkg::OFS_DIVL: divisor_low_byte <= hwdata[7:0];
        ast_pkg::OFS_DIVH: divisor_high_byte <= hwdata[7:0];
        ast_pkg::OFS_IRQ:
        begin
          global_irq_enable <= hwdata[ast_pkg::IRQ_GLOBAL];
          peripheral_irq_enable <= hwdata[ast_pkg::IRQ_PERIPH];
          transmit_irq_enable <= hwdata[ast_pkg::IRQ_TRANSMIT_IRQ_ENABLE];
          receive_irq_enable <= hwdata[ast_pkg::IRQ_RXIE];
        end
        default:
        begin
        end
      endcase
    end
  end

  // Sample-rate enable: one tick per sixteenth of a bit
  assign divisor = wide_divisor_select
                   ? {divisor_high_byte, divisor_low_byte}
                   : {8'h00, divisor_low_byte};

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !port_enable)
    begin
      div_cnt <= 16'h0000;
      prescale <= 2'h0;
      tick <= 1'b0;
    end
    else
    begin
      tick <= 1'b0;
      if (div_cnt == 16'h0000)
      begin
        div_cnt <= divisor;
        if (high_speed_divisor_select || wide_divisor_select
            || prescale == ast_pkg::SLOW_PRESCALE)
        begin
          prescale <= 2'h0;
          tick <= 1'b1;
        end
        else
        begin
          prescale <= prescale + 2'h1;
        end
      end
      else
      begin
        div_cnt <= div_cnt - 16'h0001;
      end
    end
  end

  // Transmitter
  assign tx_on = transmitter_enable && port_enable && !sync_mode;
  assign shifter_empty_flag = tx_state == ast_pkg::TX_IDLE;
  assign transmit_buffer_free_flag = tx_on && !hold_valid;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !port_enable)
    begin
      hold_valid <= 1'b0;
      transmit_holding_buffer <= 9'h000;
    end
    else if (tx_data_write && !hold_valid)
    begin
      hold_valid <= 1'b1;
      // Ninth bit is taken at write time, so set it first
      transmit_holding_buffer <= {transmit_ninth_bit, hwdata[7:0]};
    end
    else if (tx_state == ast_pkg::TX_IDLE && tx_on)
    begin
      hold_valid <= 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !port_enable)
    begin
      tx_state <= ast_pkg::TX_IDLE;
      tx_ticks <= 4'h0;
      tx_bits <= 4'h0;
      tx_len <= ast_pkg::BITS_EIGHT;
      transmit_shifter <= 9'h000;
    end
    else
    begin
      unique case (tx_state)
        ast_pkg::TX_IDLE:
        begin
          if (hold_valid && tx_on)
          begin
            transmit_shifter <= transmit_holding_buffer;
            tx_len <= nine_bit_transmit_select
                      ? ast_pkg::BITS_NINE : ast_pkg::BITS_EIGHT;
            tx_ticks <= 4'h0;
            tx_bits <= 4'h0;
            tx_state <= ast_pkg::TX_START;
          end
        end
        ast_pkg::TX_START:
        begin
          if (tick)
          begin
            tx_ticks <= tx_ticks + 4'h1;
            if (tx_ticks == ast_pkg::LAST_TICK)
            begin
              tx_state <= ast_pkg::TX_DATA;
            end
          end
        end
        ast_pkg::TX_DATA:
        begin
          if (tick)
          begin
            tx_ticks <= tx_ticks + 4'h1;
            if (tx_ticks == ast_pkg::LAST_TICK)
            begin
              transmit_shifter <= {1'b0, transmit_shifter[8:1]};
              tx_bits <= tx_bits + 4'h1;
              if (tx_bits == tx_len - 4'h1)
              begin
                tx_state <= ast_pkg::TX_STOP;
              end
            end
          end
        end
        ast_pkg::TX_STOP:
        begin
          if (tick)
          begin
            tx_ticks <= tx_ticks + 4'h1;
            if (tx_ticks == ast_pkg::LAST_TICK)
            begin
              tx_state <= ast_pkg::TX_IDLE;
            end
          end
        end
      endcase
    end
  end

  always_comb
  begin
    unique case (tx_state)
      ast_pkg::TX_START: tx_line = 1'b0;
      ast_pkg::TX_DATA: tx_line = transmit_shifter[0];
      default: tx_line = 1'b1;
    endcase
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      serial_output_pin <= 1'b1;
      serial_output_oe_n <= 1'b1;
    end
    else
    begin
      serial_output_pin <= tx_line ^ polarity_invert;
      serial_output_oe_n <= !port_enable;
    end
  end

  // Receive pin: three flip-flops, level changes when last two agree
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      rx_s1 <= 1'b1;
      rx_s2 <= 1'b1;
      rx_s3 <= 1'b1;
      rx_level <= 1'b1;
      rx_prev <= 1'b1;
    end
    else
    begin
      rx_s1 <= serial_input_pin;
      rx_s2 <= rx_s1;
      rx_s3 <= rx_s2;
      if (rx_s2 == rx_s3)
      begin
        rx_level <= rx_s3;
      end
      rx_prev <= rx_level;
    end
  end

  // Receiver
  assign rx_active = continuous_receive_enable && !sync_mode
                     && port_enable && !overrun;
  assign next_win = {rx_win[1:0], rx_level};
  assign rx_maj = (next_win[0] && next_win[1]) || (next_win[0] && next_win[2])
                  || (next_win[1] && next_win[2]);
  assign rx_done = tick && rx_ticks == ast_pkg::SAMPLE_LAST;
  assign rx_char = nine_bit_receive_select
                   ? receive_shifter : {1'b0, receive_shifter[8:1]};
  assign rx_keep = !(address_detect_enable && nine_bit_receive_select
                     && !rx_char[8]);
  assign fifo_push = rx_state == ast_pkg::RX_STOP && rx_done && rx_keep
                     && (fifo_count != (PTR_W + 1)'(FIFO_DEPTH) || fifo_pop);
  assign fifo_pop = rx_data_read && fifo_count != '0;
  assign head = fifo[rd_ptr];
  assign receive_pending_flag = port_enable && fifo_count != '0;

  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !rx_active)
    begin
      rx_state <= ast_pkg::RX_IDLE;
      rx_ticks <= 4'h0;
      rx_bits <= 4'h0;
      rx_win <= 3'h7;
      receive_shifter <= 9'h000;
    end
    else if (rx_state == ast_pkg::RX_IDLE)
    begin
      if (rx_prev && !rx_level)
      begin
        rx_state <= ast_pkg::RX_START;
        rx_ticks <= 4'h0;
        rx_bits <= 4'h0;
      end
    end
    else if (tick)
    begin
      rx_ticks <= rx_ticks + 4'h1;
      if (rx_ticks == ast_pkg::SAMPLE_FIRST
          || rx_ticks == ast_pkg::SAMPLE_MID)
      begin
        rx_win <= next_win;
      end
      if (rx_ticks == ast_pkg::SAMPLE_LAST)
      begin
        unique case (rx_state)
          ast_pkg::RX_START:
          begin
            // Half a bit in: a high line was noise, drop it quietly
            rx_state <= rx_maj ? ast_pkg::RX_IDLE
                               : ast_pkg::RX_DATA;
          end
          ast_pkg::RX_DATA:
          begin
            receive_shifter <= {rx_maj, receive_shifter[8:1]};
            rx_bits <= rx_bits + 4'h1;
            if (rx_bits == (nine_bit_receive_select
                            ? ast_pkg::BITS_NINE : ast_pkg::BITS_EIGHT)
                           - 4'h1)
            begin
              rx_state <= ast_pkg::RX_STOP;
            end
          end
          default:
          begin
            rx_state <= ast_pkg::RX_IDLE;
          end
        endcase
      end
    end
  end

  // Two-entry receive FIFO, held in flip-flops
  always_ff @(posedge core_clk)
  begin
    if (!rst_n || !port_enable)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      fifo_count <= '0;
      overrun <= 1'b0;
    end
    else
    begin
      if (fifo_push)
      begin
        wr_ptr <= wr_ptr + 1'b1;
      end
      if (fifo_pop)
      begin
        rd_ptr <= rd_ptr + 1'b1;
      end
      if (fifo_push && !fifo_pop)
      begin
        fifo_count <= fifo_count + 1'b1;
      end
      else if (fifo_pop && !fifo_push)
      begin
        fifo_count <= fifo_count - 1'b1;
      end
      // Overrun when the third character completes with two unread; reception stops
      if (rx_state == ast_pkg::RX_STOP && rx_done && rx_keep
          && fifo_count == (PTR_W + 1)'(FIFO_DEPTH) && !fifo_pop)
      begin
        overrun <= 1'b1;
      end
      else if (!continuous_receive_enable)
      begin
        overrun <= 1'b0;
      end
    end
  end

  for (genvar i = 0; i < FIFO_DEPTH; i++)
  begin : g_fifo
    always_ff @(posedge core_clk)
    begin
      if (!rst_n)
      begin
        fifo[i] <= '0;
      end
      else if (fifo_push && wr_ptr == PTR_W'(i))
      begin
        fifo[i].data <= rx_char;
        fifo[i].ferr <= !rx_maj;
      end
    end
  end

  // Interrupt requests; the shifter-empty flag stays out of them
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      tx_irq <= 1'b0;
      rx_irq <= 1'b0;
    end
    else
    begin
      tx_irq <= global_irq_enable && peripheral_irq_enable
                && transmit_irq_enable
                && transmit_buffer_free_flag;
      rx_irq <= global_irq_enable && peripheral_irq_enable
                && receive_irq_enable && receive_pending_flag;
    end
  end
endmodule

// ---- tb/ast_chk_asserts.sv ----
// Port-level assertions for the serial transceiver.
// Bound to ast_transceiver; sees only its ports.
`timescale 1ns/1ps
module ast_chk (
  input wire logic core_clk, // Clock
  input wire logic rst_n, // Reset, active low
  input wire logic hsel, // Select
  input wire logic [1:0] htrans, // Transfer type
  input wire logic hwrite, // Write
  input wire logic [2:0] hsize, // Size
  input wire logic hready, // Bus ready
  input wire logic hreadyout, // Slave ready
  input wire logic [31:0] hrdata, // Read data
  input wire logic hresp, // Response
  input wire logic serial_output_pin, // Transmit line
  input wire logic serial_output_oe_n, // Transmit drive
  input wire logic tx_irq, // Transmit request
  input wire logic rx_irq // Receive request
);
  logic take;
  logic take_rd;
  assign take = hsel && hready && htrans == ast_pkg::HTRANS_NONSEQ
    && hsize == ast_pkg::HSIZE_WORD;
  assign take_rd = take && !hwrite;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  sequence s_data;
    !hreadyout ##1 hreadyout;
  endsequence
  sequence s_sw_recent;
    $past(take, 2) || $past(take, 3) || $past(take, 4);
  endsequence
  property p_okay;
    hresp == 1'b0;
  endproperty
  a_okay: assert property (p_okay) else $error("hresp not okay");
  property p_wait_one;
    take |=> s_data;
  endproperty
  a_wait_one: assert property (p_wait_one) else $error("bad wait");
  property p_ready_idle;
    !take |=> hreadyout;
  endproperty
  a_ready_idle: assert property (p_ready_idle) else $error("stray wait");
  property p_rdata_hold;
    $changed(hrdata) |-> $past(take_rd, 2);
  endproperty
  a_rdata_hold: assert property (p_rdata_hold) else $error("hrdata moved");
  property p_reset_out;
    !$past(rst_n) |-> hreadyout && hrdata == 32'h0 && serial_output_pin
      && serial_output_oe_n && !tx_irq && !rx_irq;
  endproperty
  a_reset_out: assert property (p_reset_out) else $error("reset values");
  // A bit lasts 16 ticks of at least one clock each
  property p_bit_hold;
    $changed(serial_output_pin) && !serial_output_oe_n
      |=> $stable(serial_output_pin) [*8];
  endproperty
  a_bit_hold: assert property (p_bit_hold) else $error("short bit");
  property p_tx_irq_fall;
    $fell(tx_irq) |-> s_sw_recent;
  endproperty
  a_tx_irq_fall: assert property (p_tx_irq_fall) else $error("tx irq");
  property p_rx_irq_fall;
    $fell(rx_irq) |-> s_sw_recent;
  endproperty
  a_rx_irq_fall: assert property (p_rx_irq_fall) else $error("rx irq");
endmodule
bind ast_transceiver ast_chk u_chk (.core_clk(core_clk), .rst_n(rst_n),
  .hsel(hsel), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
  .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
  .serial_output_pin(serial_output_pin),
  .serial_output_oe_n(serial_output_oe_n), .tx_irq(tx_irq), .rx_irq(rx_irq));

// ---- tb/ast_far_end.sv ----
// Remote asynchronous serial party: frame receiver and sender.
// Assumes a pull-up on the device transmit line while it is released.
`timescale 1ns/1ps
module ast_far_end #(
  parameter int BIT_NS = 1280 // One bit time
) (
  input wire logic line_in, // Device transmit pin
  input wire logic line_oe_n, // Device drive, low drives
  input wire logic nine, // Nine data bits expected
  output logic line_out // Device receive pin
);
  logic [8:0] got [$];
  logic [8:0] sh;
  initial line_out = 1'b1;
  always
  begin
    @(negedge line_in iff !line_oe_n);
    #(BIT_NS / 2);
    sh = 9'h000;
    for (int i = 0; i < (nine ? 9 : 8); i++)
    begin
      #(BIT_NS);
      sh[i] = line_in;
    end
    #(BIT_NS);
    // Frames without a high stop are dropped
    if (line_in === 1'b1)
      got.push_back(sh);
  end
  task automatic send(input logic [8:0] d, input logic stop);
    line_out = 1'b0;
    #(BIT_NS);
    for (int i = 0; i < 8; i++)
    begin
      line_out = d[i];
      #(BIT_NS);
    end
    line_out = stop;
    #(BIT_NS);
    line_out = 1'b1;
    #(BIT_NS);
  endtask
  // Low for a quarter bit: gone by the start-bit centre
  task automatic glitch();
    line_out = 1'b0;
    #(BIT_NS / 4);
    line_out = 1'b1;
    #(2 * BIT_NS);
  endtask
endmodule

// ---- tb/testbench.sv ----
// Register-level test of the serial transceiver with a far-end model.
// Assumes this bench is the only AHB-Lite master; divisor 1, fast mode.
`timescale 1ns/1ps
module testbench;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = ast_pkg::HSIZE_WORD;
  logic [31:0] hwdata = 32'h0;
  logic hreadyout;
  logic [31:0] hrdata;
  logic hresp;
  logic rx_line;
  logic tx_line;
  logic oe_n;
  logic tx_irq;
  logic rx_irq;
  logic far_nine = 1'b0;
  logic [31:0] q;
  int miscompares = 0;
  int check_count = 0;
  int cyc = 0;
  always #20 core_clk = ~core_clk;
  ast_transceiver u_dut (.core_clk(core_clk), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .serial_input_pin(rx_line),
    .serial_output_pin(tx_line), .serial_output_oe_n(oe_n),
    .tx_irq(tx_irq), .rx_irq(rx_irq));
  ast_far_end u_far (.line_in(tx_line), .line_oe_n(oe_n), .nine(far_nine),
    .line_out(rx_line));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] s,
    input logic [31:0] e);
    check_count++;
    if (s !== e)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // Entered right after a rising edge
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= ast_pkg::HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic rc(input string n, input logic [7:0] a,
    input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(n, q, e);
  endtask
  task automatic rx(input logic [8:0] d, input logic stop);
    u_far.send(d, stop);
    @(posedge core_clk);
  endtask
  always @(posedge core_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      miscompares++;
      stop_test();
    end
  end
  initial
  begin
    repeat (8) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
    bus(1'b1, ast_pkg::OFS_DIVL, 32'h01);
    bus(1'b1, ast_pkg::OFS_DIVH, 32'h00);
    bus(1'b1, ast_pkg::OFS_TXSC, 32'h04);
    bus(1'b1, ast_pkg::OFS_RXSC, 32'h80);
    bus(1'b1, 8'h20, 32'hFF);
    rc("unmapped", 8'h20, 32'h0);
    rc("tx off", ast_pkg::OFS_IRQ, 32'h00);
    rc("divl", ast_pkg::OFS_DIVL, 32'h01);
    bus(1'b1, ast_pkg::OFS_TXSC, 32'h24);
    rc("tx free", ast_pkg::OFS_IRQ, 32'h10);
    bus(1'b1, ast_pkg::OFS_IRQ, 32'h0B);
    rc("irq reg", ast_pkg::OFS_IRQ, 32'h1B);
    chk("no tx irq", {31'h0, tx_irq}, 32'h0);
    bus(1'b1, ast_pkg::OFS_IRQ, 32'h0F);
    rc("irq on", ast_pkg::OFS_IRQ, 32'h1F);
    chk("tx irq", {31'h0, tx_irq}, 32'h1);
    far_nine = 1'b1;
    bus(1'b1, ast_pkg::OFS_TXSC, 32'h65);
    bus(1'b1, ast_pkg::OFS_TXDATA, 32'hA5);
    rc("busy", ast_pkg::OFS_TXSC, 32'h65);
    bus(1'b1, ast_pkg::OFS_TXSC, 32'h64);
    bus(1'b1, ast_pkg::OFS_TXDATA, 32'h5A);
    rc("held", ast_pkg::OFS_IRQ, 32'h0F);
    chk("tx irq held", {31'h0, tx_irq}, 32'h0);
    while (u_far.got.size() < 2)
      @(posedge core_clk);
    chk("char 1", {23'h0, u_far.got[0]}, 32'h1A5);
    chk("char 2", {23'h0, u_far.got[1]}, 32'h05A);
    do bus(1'b0, ast_pkg::OFS_TXSC, 32'h0); while (q[1] !== 1'b1);
    chk("empty", q, 32'h66);
    bus(1'b1, ast_pkg::OFS_RXSC, 32'h90);
    rx(9'h03C, 1'b1);
    chk("rx irq", {31'h0, rx_irq}, 32'h1);
    rc("pending", ast_pkg::OFS_IRQ, 32'h3F);
    rc("rx data", ast_pkg::OFS_RXDATA, 32'h3C);
    rc("popped", ast_pkg::OFS_IRQ, 32'h1F);
    rx(9'h055, 1'b0);
    rc("ferr", ast_pkg::OFS_RXSC, 32'h94);
    rc("ferr data", ast_pkg::OFS_RXDATA, 32'h55);
    u_far.glitch();
    @(posedge core_clk);
    rc("false start", ast_pkg::OFS_IRQ, 32'h1F);
    rx(9'h011, 1'b1);
    rx(9'h022, 1'b1);
    rx(9'h033, 1'b1);
    rc("overrun", ast_pkg::OFS_RXSC, 32'h92);
    rc("first", ast_pkg::OFS_RXDATA, 32'h11);
    rc("second", ast_pkg::OFS_RXDATA, 32'h22);
    rx(9'h044, 1'b1);
    rc("blocked", ast_pkg::OFS_IRQ, 32'h1F);
    bus(1'b1, ast_pkg::OFS_RXSC, 32'h80);
    bus(1'b1, ast_pkg::OFS_RXSC, 32'h90);
    rx(9'h066, 1'b1);
    rc("again", ast_pkg::OFS_IRQ, 32'h3F);
    bus(1'b1, ast_pkg::OFS_RXSC, 32'h00);
    bus(1'b1, ast_pkg::OFS_RXSC, 32'h90);
    rc("flushed", ast_pkg::OFS_IRQ, 32'h1F);
    bus(1'b1, ast_pkg::OFS_TXSC, 32'h04);
    bus(1'b1, ast_pkg::OFS_BAUD, 32'h10);
    bus(1'b1, ast_pkg::OFS_TXSC, 32'h24);
    rc("baud", ast_pkg::OFS_BAUD, 32'h50);
    chk("idle low", {31'h0, tx_line}, 32'h0);
    stop_test();
  end
endmodule
